// [design/wdt_apb.sv]
// apb slave for the watchdog registers
// assumes a standard apb master; one wait state on every access
`timescale 1ns/1ns
module wdt_apb
	import wdt_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	wdt_reg_if.slave         r
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [31:0] rdata_q, rdata_d; // read data
	logic        rdy_q, rdy_d;     // ready
	logic        err_q, err_d;     // unmapped address
	logic        done;             // completing edge
	logic        hit;              // mapped address

	assign hit = (paddr == WDT_LOAD_ADDR) | (paddr == WDT_COUNT_ADDR) |
		(paddr == WDT_CTRL_ADDR) | (paddr == WDT_CLEAR_ADDR);
	assign done      = psel & penable & rdy_q;
	assign r.wdata   = pwdata[15:0];
	assign r.wr_load = done & pwrite & (paddr == WDT_LOAD_ADDR);
	assign r.wr_ctrl = done & pwrite & (paddr == WDT_CTRL_ADDR);
	assign r.wr_clr  = done & pwrite & (paddr == WDT_CLEAR_ADDR);
	assign prdata    = rdata_q;
	assign pready    = rdy_q;
	assign pslverr   = err_q;

	// ready rises one cycle into access; write-only clear reads zero
	always_comb begin
		rdy_d   = psel & penable & ~rdy_q;
		err_d   = rdy_d & ~hit;
		rdata_d = rdata_q;
		if (rdy_d && !pwrite) begin
			case (paddr)
				WDT_LOAD_ADDR:  rdata_d = {16'h0000, r.load};
				WDT_COUNT_ADDR: rdata_d = {16'h0000, r.count};
				WDT_CTRL_ADDR:  rdata_d = {23'h000000, r.ctrl};
				default:        rdata_d = 32'h00000000;
			endcase
		end
	end

	// registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= 32'h00000000;
			rdy_q   <= 1'b0;
			err_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rdy_q   <= rdy_d;
			err_q   <= err_d;
		end
	end
endmodule

// [design/wdt_if.sv]
// carriers between the watchdog core and its two helper modules
// assumes all three modules run on the same core clock
`timescale 1ns/1ns

// register strobes from the bus slave, readback to it
interface wdt_reg_if;
	logic        wr_load;  // reload register write pulse
	logic        wr_ctrl;  // control register write pulse
	logic        wr_clr;   // service clear write pulse
	logic [15:0] wdata;    // write data, low half
	logic [15:0] load;     // reload readback
	logic [15:0] count;    // count readback
	logic [8:0]  ctrl;     // control readback
	modport slave (output wr_load, wr_ctrl, wr_clr, wdata, input load, count, ctrl);
	modport core  (input wr_load, wr_ctrl, wr_clr, wdata, output load, count, ctrl);
endinterface

// prescaled count tick from the oscillator pin
interface wdt_tick_if;
	logic [1:0] sel;  // prescaler code
	logic       run;  // counting allowed
	logic       tick; // one-cycle count pulse
	modport gen  (input sel, run, output tick);
	modport core (output sel, run, input tick);
endinterface

// [design/wdt_pkg.sv]
// watchdog timer constants: register map, field layout, reset values
// assumes a 32-bit apb register bus and a 32.768 kHz low-power oscillator pin
package wdt_pkg;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [31:0] WDT_LOAD_ADDR  = 32'hFFFF0360; // reload value
	localparam logic [31:0] WDT_COUNT_ADDR = 32'hFFFF0364; // count value, read only
	localparam logic [31:0] WDT_CTRL_ADDR  = 32'hFFFF0368; // control
	localparam logic [31:0] WDT_CLEAR_ADDR = 32'hFFFF036C; // service clear, write only

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int          WDT_CNT_W     = 16;          // counter width
	localparam int          WDT_CTRL_W    = 9;           // implemented control bits
	localparam logic [15:0] WDT_LOAD_RST  = 16'h0040;    // reload after reset
	localparam logic [15:0] WDT_COUNT_RST = 16'h0040;    // count after reset
	localparam logic [8:0]  WDT_CTRL_RST  = 9'h000;      // control after reset
	localparam logic [8:0]  WDT_CTRL_MASK = 9'h1EF;      // bit 4 reserved, reads zero
	localparam logic [15:0] WDT_CNT_ZERO  = 16'h0000;    // terminal count, down
	localparam logic [15:0] WDT_CNT_ONE   = 16'h0001;    // last step before zero
	localparam logic [15:0] WDT_CNT_FULL  = 16'hFFFF;    // terminal count, up

	// ------------------------------------------------------------
	// control field positions
	// ------------------------------------------------------------
	localparam int WDT_B_PDSTOP   = 0; // stop_in_powerdown
	localparam int WDT_B_IRQSEL   = 1; // expiry gives irq instead of reset
	localparam int WDT_B_PS_LO    = 2; // prescaler field low bit
	localparam int WDT_B_PS_HI    = 3; // prescaler field high bit
	localparam int WDT_B_WDEN     = 5; // watchdog mode
	localparam int WDT_B_PERIODIC = 6; // periodic reload
	localparam int WDT_B_EN       = 7; // timer enable
	localparam int WDT_B_UP       = 8; // count direction

	// ------------------------------------------------------------
	// prescaler and timing
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		WDT_PS_DIV1   = 2'b00,
		WDT_PS_DIV16  = 2'b01,
		WDT_PS_DIV256 = 2'b10,
		WDT_PS_RSVD   = 2'b11
	} wdt_presc_t;
	localparam logic [7:0] WDT_LAST_DIV1   = 8'h00; // last prescale step, /1
	localparam logic [7:0] WDT_LAST_DIV16  = 8'h0F; // last prescale step, /16
	localparam logic [7:0] WDT_LAST_DIV256 = 8'hFF; // last prescale step, /256
	localparam int WDT_LPOSC_HZ     = 32768; // oscillator rate
	localparam int WDT_MAX_TIMEOUT_S = 512;  // full scale at /256

endpackage

// [design/wdt_tick.sv]
// oscillator pin synchroniser and prescaler for the watchdog counter
// assumes the oscillator is far slower than the core clock
`timescale 1ns/1ns
module wdt_tick
	import wdt_pkg::*;
#(
	parameter int PS_W = 8 // prescaler width
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic lp_osc,
	wdt_tick_if.gen  t
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic            sync1_q, sync2_q, prev_q; // pin synchroniser, edge history
	logic [PS_W-1:0] ps_q, ps_d;               // prescale count
	logic            tick_q, tick_d;           // registered tick
	logic [PS_W-1:0] last;                     // last step for this divide
	logic            edge_seen;                // oscillator rising edge

	// edge taken from the second stage only
	assign edge_seen = sync2_q & ~prev_q;
	assign t.tick    = tick_q;

	// divide select; reserved code runs as the slowest setting
	always_comb begin
		case (wdt_presc_t'(t.sel))
			WDT_PS_DIV1:  last = PS_W'(WDT_LAST_DIV1);
			WDT_PS_DIV16: last = PS_W'(WDT_LAST_DIV16);
			default:      last = PS_W'(WDT_LAST_DIV256);
		endcase
	end

	// prescaler next state; held at zero while stopped
	always_comb begin
		ps_d   = ps_q;
		tick_d = 1'b0;
		if (!t.run) begin
			ps_d = '0;
		end else if (edge_seen) begin
			if (ps_q == last) begin
				ps_d   = '0;
				tick_d = 1'b1;
			end else begin
				ps_d = ps_q + PS_W'(1);
			end
		end
	end

	// registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
			ps_q    <= '0;
			tick_q  <= 1'b0;
		end else begin
			sync1_q <= lp_osc;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
			ps_q    <= ps_d;
			tick_q  <= tick_d;
		end
	end
endmodule

// [design/wdt_top.sv]
// 16-bit watchdog / general timer with apb registers
// assumes RSTN is the power-on reset only; other system resets are not wired here
`timescale 1ns/1ns
module wdt_top
	import wdt_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RSTN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [31:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        LP_OSC,
	input  wire logic        DEBUG_HALT,
	input  wire logic        PERIPH_PWR_DOWN,
	output logic             WDT_RESET_REQ,
	output logic             WDT_IRQ
);
	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	wdt_reg_if  r ();  // register strobes and readback
	wdt_tick_if t ();  // prescaled tick

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [15:0] load_q, load_d; // reload value
	logic [15:0] cnt_q, cnt_d;   // count value
	logic [8:0]  ctrl_q, ctrl_d; // control
	logic        irq_q, irq_d;   // sticky timer irq
	logic        rst_q, rst_d;   // reset request pulse

	// ------------------------------------------------------------
	// derived controls
	// ------------------------------------------------------------
	logic lock;     // watchdog mode, registers protected
	logic freeze;   // debug or power-down stop
	logic run;      // counting allowed
	logic adv;      // count step this cycle
	logic expire;   // watchdog reached zero
	logic wrap;     // normal mode terminal count

	// watchdog mode is sticky until power-on reset
	assign lock   = ctrl_q[WDT_B_WDEN];
	// power-down stop only when software asked for it
	assign freeze = DEBUG_HALT | (PERIPH_PWR_DOWN & ctrl_q[WDT_B_PDSTOP]);
	assign run    = (ctrl_q[WDT_B_EN] | lock) & ~freeze;
	// gate here too: the tick is one cycle late
	assign adv    = t.tick & run;
	// a service write in the same cycle wins over the expiry
	assign expire = adv & lock & (cnt_q == WDT_CNT_ONE) & ~r.wr_clr;
	assign wrap   = ctrl_q[WDT_B_UP] ? (cnt_q == WDT_CNT_FULL)
		: (cnt_q == WDT_CNT_ZERO);

	// prescaler control
	assign t.sel = ctrl_q[WDT_B_PS_HI:WDT_B_PS_LO];
	assign t.run = run;

	// readback
	assign r.load  = load_q;
	assign r.count = cnt_q;
	assign r.ctrl  = ctrl_q;

	// outputs, all flops
	assign WDT_RESET_REQ = rst_q;
	assign WDT_IRQ       = irq_q;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	wdt_apb u_apb (
		.clk     (CORE_CLK),
		.rst_n   (RSTN),
		.psel    (PSEL),
		.penable (PENABLE),
		.pwrite  (PWRITE),
		.paddr   (PADDR),
		.pwdata  (PWDATA),
		.prdata  (PRDATA),
		.pready  (PREADY),
		.pslverr (PSLVERR),
		.r       (r.slave)
	);

	wdt_tick #(
		.PS_W (8)
	) u_tick (
		.clk    (CORE_CLK),
		.rst_n  (RSTN),
		.lp_osc (LP_OSC),
		.t      (t.gen)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		load_d = load_q;
		ctrl_d = ctrl_q;
		cnt_d  = cnt_q;
		irq_d  = irq_q;
		rst_d  = 1'b0;
		// register writes, refused once locked
		if (r.wr_load && !lock) begin
			load_d = r.wdata;
		end
		if (r.wr_ctrl && !lock) begin
			ctrl_d = r.wdata[8:0] & WDT_CTRL_MASK;
		end
		// clear first so that a same-cycle event still sets
		if (r.wr_clr) begin
			irq_d = 1'b0;
		end
		// count step
		if (adv) begin
			if (lock) begin
				if (cnt_q == WDT_CNT_ZERO) begin
					cnt_d = load_q;
				end else begin
					cnt_d = cnt_q - WDT_CNT_ONE;
				end
			end else if (wrap) begin
				// periodic reloads, free-running rolls over
				if (ctrl_q[WDT_B_PERIODIC]) begin
					cnt_d = load_q;
				end else if (ctrl_q[WDT_B_UP]) begin
					cnt_d = WDT_CNT_ZERO;
				end else begin
					cnt_d = WDT_CNT_FULL;
				end
				irq_d = 1'b1;
			end else if (ctrl_q[WDT_B_UP]) begin
				cnt_d = cnt_q + WDT_CNT_ONE;
			end else begin
				cnt_d = cnt_q - WDT_CNT_ONE;
			end
		end
		// expiry: one reset pulse or a held flag
		if (expire) begin
			if (ctrl_q[WDT_B_IRQSEL]) begin
				irq_d = 1'b1;
			end else begin
				rst_d = 1'b1;
			end
		end
		// service: reload wins over a count step
		if (r.wr_clr && lock) begin
			cnt_d = load_q;
		end
		// entering watchdog mode starts a fresh period
		if (r.wr_ctrl && !lock && r.wdata[WDT_B_WDEN]) begin
			cnt_d = load_q;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// only the power-on reset touches this state; other resets
	// in the system never reach it, so the watchdog keeps going
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			load_q <= WDT_LOAD_RST;
			cnt_q  <= WDT_COUNT_RST;
			ctrl_q <= WDT_CTRL_RST;
			irq_q  <= 1'b0;
			rst_q  <= 1'b0;
		end else begin
			load_q <= load_d;
			cnt_q  <= cnt_d;
			ctrl_q <= ctrl_d;
			irq_q  <= irq_d;
			rst_q  <= rst_d;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RSTN);

	// locked reload ignores writes
	lock_load_a: assert property (
		lock && r.wr_load |=> load_q == $past(load_q))
		else $error("reload changed while locked");

	// locked control ignores writes
	lock_ctrl_a: assert property (
		lock && r.wr_ctrl |=> ctrl_q == $past(ctrl_q))
		else $error("control changed while locked");

	// watchdog step is a decrement by one
	wd_dec_a: assert property (
		lock && adv && cnt_q > WDT_CNT_ONE && !r.wr_clr
		|=> cnt_q == 16'($past(cnt_q) - 16'h0001))
		else $error("watchdog step not a decrement");

	// reset expiry is a single pulse
	expire_rst_a: assert property (
		expire && !ctrl_q[WDT_B_IRQSEL]
		|=> WDT_RESET_REQ ##1 !WDT_RESET_REQ)
		else $error("reset request not a single pulse");

	// irq expiry raises the flag, no reset
	expire_irq_a: assert property (
		expire && ctrl_q[WDT_B_IRQSEL] |=> WDT_IRQ && !WDT_RESET_REQ)
		else $error("irq expiry wrong");

	// irq holds until a clear write
	irq_hold_a: assert property (
		WDT_IRQ && !r.wr_clr |=> WDT_IRQ)
		else $error("irq dropped without clear");

	// service write reloads the count
	service_a: assert property (
		lock && r.wr_clr |=> cnt_q == $past(load_q) && !WDT_RESET_REQ)
		else $error("service did not reload");

	// debug halt freezes the count
	freeze_dbg_a: assert property (
		DEBUG_HALT && !r.wr_clr && !r.wr_ctrl |=> $stable(cnt_q))
		else $error("count moved in debug halt");

	// power-down stop freezes the count
	pd_stop_a: assert property (
		PERIPH_PWR_DOWN && ctrl_q[WDT_B_PDSTOP] && !r.wr_clr && !r.wr_ctrl
		|=> $stable(cnt_q))
		else $error("count moved in power-down stop");

	// periodic down overflow reloads
	reload_ovf_a: assert property (
		!lock && adv && !ctrl_q[WDT_B_UP] && ctrl_q[WDT_B_PERIODIC]
		&& cnt_q == WDT_CNT_ZERO && !r.wr_ctrl
		|=> cnt_q == $past(load_q) && WDT_IRQ)
		else $error("periodic overflow did not reload");

	// reserved control bit stays zero
	ctrl_rsvd_a: assert property (
		ctrl_q[4] == 1'b0)
		else $error("reserved control bit set");

endmodule

// [verification/watchdog_timer_16bit_test.sv]
// testbench for the watchdog timer: apb register sequences, a hand-driven oscillator pin
// assumes wdt_top answers apb with one wait state and RSTN is the only power-on reset
`timescale 1ns/1ns
module watchdog_timer_16bit_test;
	import wdt_pkg::*;

	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic        clk;       // core clock
	logic        rstn;      // power-on reset, active low
	logic        psel;      // apb select
	logic        penable;   // apb access phase
	logic        pwrite;    // apb direction
	logic [31:0] paddr;     // apb address
	logic [31:0] pwdata;    // apb write data
	logic [31:0] prdata;    // apb read data
	logic        pready;    // apb answer
	logic        pslverr;   // apb error
	logic        osc;       // oscillator pin, pulsed by hand
	logic        halt;      // debugger holds core
	logic        pwr_dn;    // peripherals powered down
	logic        rst_req;   // expiry reset request
	logic        irq;       // timer irq
	int          n_errors;  // mismatches
	int          n_checks;  // comparisons
	int          n_rst;     // reset request pulses seen
	int          cyc;       // cycles since start
	logic [15:0] e;         // expected count
	logic [31:0] q;         // read data scratch
	logic        er;        // error scratch
	logic [8:0]  ctl;       // control scratch
	int          dv[3] = '{1, 16, 256}; // divide per prescaler code

	wdt_top wdt_top_i (
		.CORE_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.LP_OSC(osc), .DEBUG_HALT(halt), .PERIPH_PWR_DOWN(pwr_dn),
		.WDT_RESET_REQ(rst_req), .WDT_IRQ(irq)
	);

	// ----------------------------------------------------------------
	// clock, pulse counter, hang guard
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// a one-cycle request counts once; a stuck one counts many times
	always @(posedge clk) begin
		if (rst_req === 1'b1) begin
			n_rst <= n_rst + 1;
		end
	end

	// ceiling well above the ~3300 cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// bus, pin and compare tasks
	// ----------------------------------------------------------------
	// one apb transfer; request held until the rising edge that samples pready high,
	// answer taken at that same edge, then one more edge so effects are visible
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] rq, output logic re);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rq = prdata;
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, er);
	endtask

	task automatic chk_word(input string n, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic chk_bit(input string n, input logic x, input logic g);
		n_checks++;
		if (g !== x) begin
			n_errors++;
			$display("mismatch %s expected %b seen %b", n, x, g);
		end
	endtask

	task automatic rd(input string n, input logic [31:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000, q, er);
		chk_word(n, x, q);
	endtask

	task automatic cnt(input logic [15:0] x);
		rd("count", WDT_COUNT_ADDR, {16'h0000, x});
	endtask

	// oscillator edges slow enough for the two-flop synchroniser, then settle
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clk);
			osc <= 1'b1;
			repeat (4) @(posedge clk);
			osc <= 1'b0;
			repeat (3) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask

	task automatic rst();
		rstn <= 1'b0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, osc, halt, pwr_dn} = 6'h00;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		rstn = 1'b0;
		n_errors = 0;
		n_checks = 0;
		n_rst = 0;
		cyc = 0;
		rst();
		// reset values, read-only count, write-only clear, unmapped place
		rd("reload", WDT_LOAD_ADDR, 32'h0000_0040);
		cnt(16'h0040);
		rd("control", WDT_CTRL_ADDR, 32'h0000_0000);
		wr(WDT_COUNT_ADDR, 32'h0000_1234);
		cnt(16'h0040);
		rd("clear", WDT_CLEAR_ADDR, 32'h0000_0000);
		apb(1'b0, 32'hFFFF_0370, 32'h0000_0000, q, er);
		chk_bit("unmapped err", 1'b1, er);
		$display("test registers done");
		// prescaler codes: divide by 1, 16, 256, normal mode down
		e = 16'h0040;
		for (int i = 0; i < 3; i++) begin
			ctl = 9'h000;
			ctl[3:2] = i[1:0];
			wr(WDT_CTRL_ADDR, {23'h0, ctl});
			ctl[7:6] = 2'b11;
			wr(WDT_CTRL_ADDR, {23'h0, ctl});
			pulse(dv[i] - 1);
			cnt(e);
			pulse(1);
			e = e - 16'h0001;
			cnt(e);
		end
		$display("test prescaler done");
		// wrap, reload and irq in periodic, free-running and up modes
		wr(WDT_CTRL_ADDR, 32'h0000_00C0);
		wr(WDT_LOAD_ADDR, 32'h0000_0003);
		pulse(e);
		cnt(16'h0000);
		pulse(1);
		cnt(16'h0003);
		chk_bit("irq", 1'b1, irq);
		wr(WDT_CLEAR_ADDR, 32'h0000_00A5);
		chk_bit("irq", 1'b0, irq);
		wr(WDT_CTRL_ADDR, 32'h0000_0080);
		pulse(4);
		cnt(16'hFFFF);
		chk_bit("irq", 1'b1, irq);
		wr(WDT_CLEAR_ADDR, 32'h0000_0000);
		wr(WDT_CTRL_ADDR, 32'h0000_01C0);
		pulse(1);
		cnt(16'h0003);
		pulse(1);
		cnt(16'h0004);
		$display("test normal done");
		// debug hold and power-down stop option
		halt <= 1'b1;
		pulse(2);
		cnt(16'h0004);
		halt <= 1'b0;
		pulse(1);
		cnt(16'h0005);
		pwr_dn <= 1'b1;
		pulse(1);
		cnt(16'h0006);
		wr(WDT_CTRL_ADDR, 32'h0000_01C1);
		pulse(2);
		cnt(16'h0006);
		pwr_dn <= 1'b0;
		pulse(1);
		cnt(16'h0007);
		$display("test freeze done");
		// watchdog with reset chosen: lock, service, expiry
		wr(WDT_CTRL_ADDR, 32'h0000_00A0);
		cnt(16'h0003);
		wr(WDT_LOAD_ADDR, 32'h0000_0009);
		wr(WDT_CTRL_ADDR, 32'h0000_0000);
		rd("reload", WDT_LOAD_ADDR, 32'h0000_0003);
		rd("control", WDT_CTRL_ADDR, 32'h0000_00A0);
		pulse(2);
		cnt(16'h0001);
		wr(WDT_CLEAR_ADDR, 32'h0000_0011);
		cnt(16'h0003);
		chk_word("reset pulses", 32'd0, n_rst);
		pulse(3);
		cnt(16'h0000);
		chk_word("reset pulses", 32'd1, n_rst);
		chk_bit("irq", 1'b0, irq);
		$display("test watchdog reset done");
		// power-on reset frees the lock; watchdog with irq chosen
		rst();
		rd("reload", WDT_LOAD_ADDR, 32'h0000_0040);
		wr(WDT_LOAD_ADDR, 32'h0000_0002);
		wr(WDT_CTRL_ADDR, 32'h0000_00A2);
		pulse(2);
		chk_bit("irq", 1'b1, irq);
		chk_word("reset pulses", 32'd1, n_rst);
		repeat (20) @(posedge clk);
		chk_bit("irq", 1'b1, irq);
		wr(WDT_CLEAR_ADDR, 32'h0000_0000);
		chk_bit("irq", 1'b0, irq);
		cnt(16'h0002);
		$display("test watchdog irq done");
		results();
	end
endmodule
